// >>> shared/pss_pkg.sv
// constants, register map and types of the parameter scan sequencer
// assumes a 100 MHz ref_clk and a 32-bit plain register port
`default_nettype none
package pss_pkg;
	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int TICK_NS = 1000000;
	localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
	localparam logic [6:0] DIV_STEPS = 7'h40;
	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_CMD = 8'h04;
	localparam logic [7:0] OFS_STATE = 8'h08;
	localparam logic [7:0] OFS_DURATION = 8'h0c;
	localparam logic [7:0] OFS_LIMIT = 8'h10;
	localparam logic [7:0] LIMIT_STRIDE = 8'h04;
	localparam int LIMIT_COUNT = 10;
	localparam int CMD_RUN = 0;
	localparam int CMD_PAUSE = 1;
	localparam int CMD_RESET = 2;
	localparam int CTRL_W = 17;
	localparam int CTRL_EN = 16;
	localparam logic [31:0] DURATION_MAX = 32'h001a5e00;
	localparam logic [31:0] DURATION_RESET = 32'h0000003c;
	localparam logic [31:0] MS_PER_S = 32'h000003e8;
	localparam logic [4:0] DWELL_IDX_MAX = 5'h10;
	// dwell per step in milliseconds, by index
	localparam logic [21:0] DWELL_MS [17] = '{
		22'h8, 22'h10, 22'h1f, 22'h4e, 22'h9b, 22'h1d5, 22'h3aa,
		22'h753, 22'h1250, 22'h249f, 22'h6dd8, 22'hdbba, 22'h1b774,
		22'h52468, 22'ha4cb8, 22'h149970, 22'h2932e0};
	// ----------------------------------------------------------------
	// quantities; units mHz, nV, 0.1 mV, mV, mV
	// ----------------------------------------------------------------
	localparam logic [2:0] QTY_FREQ = 3'h0;
	localparam logic [2:0] QTY_AMP = 3'h1;
	localparam logic [2:0] QTY_DC = 3'h2;
	localparam logic [2:0] QTY_AUX2 = 3'h4;
	localparam logic [31:0] LIMIT_MIN [5] = '{32'h1, 32'h1,
		32'hffff3cb0, 32'hffffd6fc, 32'hffffd6fc};
	localparam logic [31:0] LIMIT_MAX [5] = '{32'hee6b2800,
		32'h77359400, 32'h0000c350, 32'h00002904, 32'h00002904};
	localparam logic [3:0] SIG_DIGITS [5] = '{4'h6, 4'h3, 4'h3,
		4'h5, 4'h5};
	localparam logic [1:0] END_REPEAT = 2'h1;
	localparam logic [1:0] END_UPDOWN = 2'h2;
	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_OFF = 3'b000,
		ST_RESET = 3'b001,
		ST_RUN = 3'b010,
		ST_PAUSE = 3'b011,
		ST_DONE = 3'b100
	} pss_state_t;
	typedef enum logic [1:0] {
		PH_DIVN = 2'b00,
		PH_DIVV = 2'b01,
		PH_DWELL = 2'b10
	} pss_phase_t;
	typedef struct packed {
		logic enable;
		logic [2:0] pad;
		logic [4:0] dwellIdx;
		logic dcHold;
		logic ampHold;
		logic [1:0] endMode;
		logic logSpacing;
		logic [2:0] qty;
	} pss_ctrl_t;
	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} pss_bus_t;
	typedef struct packed {
		logic [2:0] state;
		logic [2:0] qty;
		logic [31:0] value;
		logic update;
		logic ampFreeze;
		logic dcFreeze;
	} pss_out_t;
endpackage
`default_nettype wire

// >>> rtl/pss_divider.sv
// serial restoring divider, one quotient bit per clock
// assumes den is nonzero and the quotient fits in 32 bits
`timescale 1ns/10ps
`default_nettype none
module pss_divider (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic start,
	input wire logic [63:0] num,
	input wire logic [31:0] den,
	output logic busy,
	output logic [31:0] quot
);
	import pss_pkg::*;
	logic [63:0] work, next_work;
	logic [31:0] rem, next_rem;
	logic [6:0] count, next_count;
	logic next_busy;
	logic [32:0] trial;

	always_comb begin
		next_work = work;
		next_rem = rem;
		next_count = count;
		next_busy = busy;
		trial = {rem, work[63]} - {1'b0, den};
		if (start) begin
			next_work = num;
			next_rem = '0;
			next_count = DIV_STEPS;
			next_busy = 1'b1;
		end else if (busy) begin
			if (trial[32]) begin
				next_rem = {rem[30:0], work[63]};
				next_work = {work[62:0], 1'b0};
			end else begin
				next_rem = trial[31:0];
				next_work = {work[62:0], 1'b1};
			end
			next_count = count - 7'h1;
			next_busy = count != 7'h1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			work <= '0;
			rem <= '0;
			count <= '0;
			busy <= 1'b0;
		end else begin
			work <= next_work;
			rem <= next_rem;
			count <= next_count;
			busy <= next_busy;
		end
	end

	// quotient bits have shifted into the low word by the end
	assign quot = work[31:0];
endmodule // pss_divider
`default_nettype wire

// >>> rtl/pss_scan_sequencer.sv
// parameter scan sequencer: register port, run states, step engine
// assumes reset_n synchronous, one-cycle strobes never both at once
//
// Summary of operation
// - quantity code 0 to 4 selects output
// - spacing code 0 linear, 1 logarithmic
// - end code 0 once, 1 repeat, 2 up/down
// - duration in seconds, capped at twenty days
// - amplitude sweep attenuator hold bit
// - dc level sweep attenuator hold bit
// - hold bit freezes attenuator relays while sweeping
// - dwell index 0 to 16, 8 ms..45 min
// - each step dwells the selected interval
// - enabling loads begin value, does not start
// - run starts or resumes, ignored when running
// - pause freezes value, ignored when paused
// - reset returns to begin value, stays stopped
// - state code 0 off to 4 done
// - frequency limits rounded, kept 1 mHz..4 MHz
// - amplitude limits rounded, kept 1 nV..2 V
// - dc limits rounded, kept -5 V..+5 V
// - first aux limits +-10.5 V, 1 mV
// - second aux limits +-10.5 V, 1 mV
//
// Chosen here: the placing of the registers and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module pss_scan_sequencer #(
	parameter int TICK_LEN = pss_pkg::TICK_CYCLES
) (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire pss_pkg::pss_bus_t bus,
	output logic [31:0] rdata,
	output var pss_pkg::pss_out_t out
);
	import pss_pkg::*;

	// ----------------------------------------------------------------
	// arithmetic helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] roundSig(input logic [31:0] mag,
			input logic [3:0] digits);
		logic [63:0] lim;
		logic [63:0] q;
		logic [63:0] r;
		lim = 64'h1;
		q = 64'h1;
		for (int d = 0; d < 16; d++) begin
			if (4'(d) < digits) lim = lim * 64'ha;
		end
		for (int d = 0; d < 10; d++) begin
			if (64'(mag) >= lim) begin
				lim = lim * 64'ha;
				q = q * 64'ha;
			end
		end
		r = (64'(mag) + (q >> 1)) / q * q;
		return (r[63:32] != '0) ? '1 : r[31:0];
	endfunction

	function automatic logic [31:0] limitValue(input logic [2:0] q,
			input logic [31:0] raw);
		logic sgn;
		logic neg;
		logic [31:0] r;
		sgn = q >= QTY_DC;
		neg = sgn && raw[31];
		r = roundSig(neg ? 32'(-raw) : raw, SIG_DIGITS[q]);
		r = neg ? 32'(-r) : r;
		if (sgn) begin
			if ($signed(r) < $signed(LIMIT_MIN[q])) r = LIMIT_MIN[q];
			if ($signed(r) > $signed(LIMIT_MAX[q])) r = LIMIT_MAX[q];
		end else begin
			if (r < LIMIT_MIN[q]) r = LIMIT_MIN[q];
			if (r > LIMIT_MAX[q]) r = LIMIT_MAX[q];
		end
		return r;
	endfunction

	// approximate log2 / exp2 with a linear mantissa; good enough for
	// geometric spacing, endpoints are substituted exactly
	function automatic logic [20:0] mlog(input logic [31:0] x);
		logic [4:0] p;
		logic [31:0] s;
		p = '0;
		for (int i = 0; i < 32; i++) begin
			if (x[i]) p = 5'(i);
		end
		s = x << (5'h1f - p);
		return {p, s[30:15]};
	endfunction

	function automatic logic [31:0] mexp(input logic [20:0] l);
		logic [47:0] m;
		m = {31'h0, 1'b1, l[15:0]} << l[20:16];
		return m[47:16];
	endfunction

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	pss_ctrl_t ctrl, next_ctrl, newCtrl;
	pss_state_t state, next_state;
	pss_phase_t phase, next_phase;
	logic [31:0] duration, next_duration;
	logic [31:0] limit [LIMIT_COUNT];
	logic [31:0] next_limit [LIMIT_COUNT];
	logic [31:0] k, next_k, stepsN, next_stepsN;
	logic dir, next_dir, divStart, next_divStart;
	logic [31:0] tickCount, next_tickCount;
	logic tick, next_tick;
	logic [21:0] dwellLeft, next_dwellLeft;
	logic [31:0] value, next_value;
	logic [31:0] next_rdata;
	pss_out_t next_out;
	logic next_update;
	logic ctrlWr, cmdWr, runCmd, pauseCmd, rstCmd, enRise, enFall;
	logic divBusy, divDone;
	logic [31:0] divQuot, divDen, beginVal, endVal, stepValue;
	logic [63:0] divNum, product;
	logic signedQ, useLog;
	logic [33:0] endA, endB, diff, stepSum;
	logic [32:0] diffMag;

	assign ctrlWr = bus.wr && bus.addr == OFS_CTRL;
	assign cmdWr = bus.wr && bus.addr == OFS_CMD;
	// reset outranks pause, pause outranks run
	assign rstCmd = cmdWr && bus.wdata[CMD_RESET];
	assign pauseCmd = cmdWr && bus.wdata[CMD_PAUSE] && !rstCmd;
	assign runCmd = cmdWr && bus.wdata[CMD_RUN] && !bus.wdata[CMD_PAUSE]
		&& !rstCmd;
	assign enRise = ctrlWr && bus.wdata[CTRL_EN] && !ctrl.enable;
	assign enFall = ctrlWr && !bus.wdata[CTRL_EN];
	assign beginVal = limit[4'({ctrl.qty, 1'b0})];
	assign endVal = limit[4'({ctrl.qty, 1'b1})];
	assign divDone = !divStart && !divBusy;

	pss_divider u_divider (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.start(divStart),
		.num(divNum),
		.den(divDen),
		.busy(divBusy),
		.quot(divQuot)
	);

	// ----------------------------------------------------------------
	// limit storage, one pair per quantity
	// ----------------------------------------------------------------
	for (genvar i = 0; i < LIMIT_COUNT; i++) begin : g_limit
		localparam logic [7:0] OFS = 8'(OFS_LIMIT + 8'(i) * LIMIT_STRIDE);
		always_comb begin
			next_limit[i] = limit[i];
			if (bus.wr && bus.addr == OFS) begin
				next_limit[i] = limitValue(3'(i / 2), bus.wdata);
			end
		end
		always_ff @(posedge ref_clk) begin
			if (!reset_n) limit[i] <= LIMIT_MIN[i / 2];
			else limit[i] <= next_limit[i];
		end
	end

	// ----------------------------------------------------------------
	// step value engine
	// ----------------------------------------------------------------
	always_comb begin
		signedQ = ctrl.qty >= QTY_DC;
		// log spacing needs both ends strictly positive
		useLog = ctrl.logSpacing && beginVal != '0 && endVal != '0
			&& !(signedQ && (beginVal[31] || endVal[31]));
		if (useLog) begin
			endA = 34'(mlog(beginVal));
			endB = 34'(mlog(endVal));
		end else if (signedQ) begin
			endA = 34'($signed(beginVal));
			endB = 34'($signed(endVal));
		end else begin
			endA = {2'b00, beginVal};
			endB = {2'b00, endVal};
		end
		diff = endB - endA;
		diffMag = diff[33] ? 33'(-diff) : diff[32:0];
		product = 64'(diffMag) * 64'(k);
		stepSum = diff[33] ? endA - 34'(divQuot) : endA + 34'(divQuot);
		stepValue = useLog ? mexp(stepSum[20:0]) : stepSum[31:0];
		if (phase == PH_DIVN) begin
			divNum = 64'(duration) * 64'(MS_PER_S);
			divDen = 32'(DWELL_MS[ctrl.dwellIdx]);
		end else begin
			divNum = product;
			divDen = stepsN;
		end
	end

	// ----------------------------------------------------------------
	// registers and run control
	// ----------------------------------------------------------------
	always_comb begin
		newCtrl = pss_ctrl_t'(bus.wdata[CTRL_W-1:0]);
		newCtrl.pad = '0;
		if (newCtrl.dwellIdx > DWELL_IDX_MAX) begin
			newCtrl.dwellIdx = DWELL_IDX_MAX;
		end
		// an unknown quantity code leaves the selection alone
		if (newCtrl.qty > QTY_AUX2) newCtrl.qty = ctrl.qty;
		next_ctrl = ctrlWr ? newCtrl : ctrl;
		next_duration = duration;
		if (bus.wr && bus.addr == OFS_DURATION) begin
			next_duration = (bus.wdata > DURATION_MAX) ? DURATION_MAX
				: bus.wdata;
		end
		next_tick = tickCount == 32'(TICK_LEN - 1);
		next_tickCount = next_tick ? '0 : tickCount + 32'h1;
		next_state = state;
		next_phase = phase;
		next_k = k;
		next_stepsN = stepsN;
		next_dir = dir;
		next_divStart = 1'b0;
		next_dwellLeft = dwellLeft;
		next_value = value;
		next_update = 1'b0;
		if (enFall) begin
			next_state = ST_OFF;
		end else if (enRise || (state != ST_OFF && rstCmd)) begin
			next_state = ST_RESET;
			next_value = beginVal;
			next_update = 1'b1;
		end else if (state == ST_RUN && pauseCmd) begin
			next_state = ST_PAUSE;
		end else if (runCmd && (state == ST_RESET || state == ST_DONE)) begin
			next_state = ST_RUN;
			next_phase = PH_DIVN;
			next_divStart = 1'b1;
			next_k = '0;
			next_dir = 1'b0;
		end else if (runCmd && state == ST_PAUSE) begin
			next_state = ST_RUN;
		end else if (state == ST_RUN) begin
			case (phase)
				PH_DIVN: begin
					if (divDone) begin
						next_stepsN = (divQuot == '0) ? 32'h1 : divQuot;
						next_phase = PH_DIVV;
						next_divStart = 1'b1;
					end
				end
				PH_DIVV: begin
					if (divDone) begin
						// exact endpoints, no approximation drift
						if (k == '0) next_value = beginVal;
						else if (k == stepsN) next_value = endVal;
						else next_value = stepValue;
						next_update = 1'b1;
						next_phase = PH_DWELL;
						next_dwellLeft = DWELL_MS[ctrl.dwellIdx];
					end
				end
				PH_DWELL: begin
					if (tick && dwellLeft > 22'h1) begin
						next_dwellLeft = dwellLeft - 22'h1;
					end else if (tick) begin
						next_phase = PH_DIVV;
						next_divStart = 1'b1;
						if (!dir && k >= stepsN) begin
							case (ctrl.endMode)
								END_REPEAT: next_k = '0;
								END_UPDOWN: begin
									next_dir = 1'b1;
									next_k = stepsN - 32'h1;
								end
								default: begin
									next_state = ST_DONE;
									next_divStart = 1'b0;
									next_phase = PH_DWELL;
								end
							endcase
						end else if (dir && k == '0) begin
							next_dir = 1'b0;
							next_k = 32'h1;
						end else begin
							next_k = dir ? k - 32'h1 : k + 32'h1;
						end
					end
				end
				default: next_phase = PH_DWELL;
			endcase
		end
		next_rdata = '0;
		if (bus.rd) begin
			case (bus.addr)
				OFS_CTRL: next_rdata = 32'(ctrl);
				OFS_STATE: next_rdata = 32'(state);
				OFS_DURATION: next_rdata = duration;
				default: begin
					for (int i = 0; i < LIMIT_COUNT; i++) begin
						if (bus.addr == 8'(OFS_LIMIT + 8'(i) * LIMIT_STRIDE)) begin
							next_rdata = limit[i];
						end
					end
				end
			endcase
		end
		next_out.state = next_state;
		next_out.qty = next_ctrl.qty;
		next_out.value = next_value;
		next_out.update = next_update;
		// relays stay put for the whole enabled scan session
		next_out.ampFreeze = next_state != ST_OFF
			&& next_ctrl.qty == QTY_AMP && next_ctrl.ampHold;
		next_out.dcFreeze = next_state != ST_OFF
			&& next_ctrl.qty == QTY_DC && next_ctrl.dcHold;
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			ctrl <= '0;
			duration <= DURATION_RESET;
			state <= ST_OFF;
			phase <= PH_DWELL;
			k <= '0;
			stepsN <= 32'h1;
			dir <= 1'b0;
			divStart <= 1'b0;
			tickCount <= '0;
			tick <= 1'b0;
			dwellLeft <= '0;
			value <= '0;
			rdata <= '0;
			out <= '0;
		end else begin
			ctrl <= next_ctrl;
			duration <= next_duration;
			state <= next_state;
			phase <= next_phase;
			k <= next_k;
			stepsN <= next_stepsN;
			dir <= next_dir;
			divStart <= next_divStart;
			tickCount <= next_tickCount;
			tick <= next_tick;
			dwellLeft <= next_dwellLeft;
			value <= next_value;
			rdata <= next_rdata;
			out <= next_out;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);

	chk_enable_loads: assert property (
		enRise |=> state == ST_RESET && out.value == $past(beginVal))
		else $error("enable did not load begin value");
	chk_run_ignored: assert property (
		state == ST_RUN && runCmd && !ctrlWr |=> state == ST_RUN)
		else $error("run left the running state");
	chk_pause_holds: assert property (
		state == ST_PAUSE && !cmdWr && !ctrlWr |=> state == ST_PAUSE
			&& $stable(out.value))
		else $error("paused value moved");
	chk_reset_begin: assert property (
		state != ST_OFF && rstCmd && !ctrlWr |=> state == ST_RESET
			&& out.value == $past(beginVal)
			##1 (state != ST_RUN || $past(runCmd)))
		else $error("reset did not return to begin");
	chk_off_code: assert property (
		enFall |=> out.state == 3'h0 && rdata == '0)
		else $error("disable not reported as code 0");
	chk_duration_cap: assert property (
		duration <= DURATION_MAX)
		else $error("duration above twenty days");
	chk_dwell_load: assert property (
		state == ST_RUN && phase == PH_DIVV && divDone && !cmdWr
			&& !ctrlWr |=> dwellLeft == DWELL_MS[$past(ctrl.dwellIdx)]
			&& out.update)
		else $error("dwell not loaded from table");
	chk_once_done: assert property (
		$rose(state == ST_DONE) |-> k == stepsN && out.value == endVal)
		else $error("done reached away from end value");
	chk_freq_limits: assert property (
		limit[0] >= LIMIT_MIN[0] && limit[0] <= LIMIT_MAX[0]
			&& limit[1] >= LIMIT_MIN[0] && limit[1] <= LIMIT_MAX[0])
		else $error("frequency limit out of range");
endmodule // pss_scan_sequencer
`default_nettype wire

// >>> test/pss_host_model.sv
// remote host model: drives the plain register port of the sequencer
// assumes one-cycle strobes, read data in the cycle after the strobe
`timescale 1ns/10ps
`default_nettype none
module pss_host_model (
	input wire logic ref_clk,
	output var pss_pkg::pss_bus_t bus,
	output logic expPush,
	output logic [31:0] expData
);
	import pss_pkg::*;
	initial begin
		bus = '0;
		expPush = 1'b0;
		expData = '0;
	end
	// ----------------------------------------------------------------
	// bus cycles
	// ----------------------------------------------------------------
	// idle lines carry junk so a stale address never looks valid
	task automatic drop();
		bus <= '{8'($urandom), 32'($urandom), 1'b0, 1'b0};
		expPush <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		bus <= '{a, d, 1'b1, 1'b0};
		@(posedge ref_clk);
		drop();
	endtask
	// expected word travels with the strobe, noted by the bench
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge ref_clk);
		bus <= '{a, 32'($urandom), 1'b0, 1'b1};
		expPush <= 1'b1;
		expData <= e;
		@(posedge ref_clk);
		drop();
	endtask
endmodule // pss_host_model
`default_nettype wire

// >>> test/pss_scan_sequencer_tb.sv
// self-checking bench of the parameter scan sequencer
// assumes the host model as bus master and a short dwell tick
`timescale 1ns/10ps
`default_nettype none
module pss_scan_sequencer_tb;
	import pss_pkg::*;
	logic ref_clk = 1'b0;
	logic reset_n = 1'b0;
	pss_bus_t bus;
	logic [31:0] rdata;
	pss_out_t out;
	logic expPush;
	logic [31:0] expData;
	int errCount = 0;
	int checkCount = 0;
	int updCount = 0;
	int cyc = 0;
	int lastUpd = 0;
	bit gapOn = 1'b0;
	bit rdPend = 1'b0;
	logic [31:0] rdQ[$];
	logic [31:0] updQ[$];
	logic [31:0] lo = '0;
	logic [31:0] hi = '1;
	logic [31:0] limW [10] = '{32'h0012d687, 32'hee6b2801, 32'h0001e240,
		32'h0001e26c, 32'hffffcfc7, 32'h0000ea60, 32'h000011d7,
		32'hffffd508, 32'hffffee29, 32'h00002af8};
	logic [31:0] limE [10] = '{32'h0012d68a, 32'hee6b2800, 32'h0001e078,
		32'h0001e460, 32'hffffcff4, 32'h0000c350, 32'h000011d7,
		32'hffffd6fc, 32'hffffee29, 32'h00002904};

	always #5 ref_clk = ~ref_clk;

	pss_scan_sequencer #(.TICK_LEN(10)) i_pss_scan_sequencer (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.bus(bus),
		.rdata(rdata),
		.out(out)
	);
	pss_host_model i_pss_host_model (
		.ref_clk(ref_clk),
		.bus(bus),
		.expPush(expPush),
		.expData(expData)
	);
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic check(input string n, input logic [31:0] s,
		input logic [31:0] e);
		checkCount++;
		if (s !== e) begin
			errCount++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic printVerdict();
		$display("checks %0d errors %0d", checkCount, errCount);
		if (errCount == 0 && checkCount > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		i_pss_host_model.wr(a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		i_pss_host_model.rd(a, e);
	endtask
	task automatic cmd(input int b);
		wr(OFS_CMD, 32'h1 << b);
	endtask
	task automatic st(input logic [2:0] e);
		@(posedge ref_clk);
		#1;
		check("state", 32'(out.state), 32'(e));
	endtask
	task automatic waitU(input int n);
		for (int i = 0; i < 12000 && updCount < n; i++) begin
			@(posedge ref_clk);
		end
		check("updates", 32'(updCount >= n), 32'h1);
	endtask
	function automatic logic [31:0] ctl(input logic [2:0] q,
		input logic lg, input logic [1:0] em, input logic ah,
		input logic dh, input logic [4:0] dw, input logic en);
		pss_ctrl_t c;
		c = '{en, 3'h0, dw, dh, ah, em, lg, q};
		return 32'(c);
	endfunction
	// ----------------------------------------------------------------
	// result watcher
	// ----------------------------------------------------------------
	always @(posedge ref_clk) begin
		cyc = cyc + 1;
		if (rdPend) check("rdata", rdata, rdQ.pop_front());
		rdPend = expPush;
		if (expPush) rdQ.push_back(expData);
		if (reset_n && out.update === 1'b1) begin
			if (updQ.size() > 0) begin
				check("value", out.value, updQ.pop_front());
			end else begin
				check("range", 32'(out.value >= lo && out.value <= hi), 1);
			end
			if (gapOn) begin
				check("gap", 32'(cyc - lastUpd inside {[1540:1800]}), 1);
			end
			lastUpd = cyc;
			updCount++;
		end
	end
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	initial begin
		int r;
		logic [31:0] v;
		logic [31:0] c;
		r = $urandom(32'he3165443);
		repeat (5) @(posedge ref_clk);
		reset_n <= 1'b1;
		rd(OFS_CTRL, 32'h0);
		rd(OFS_STATE, 32'h0);
		rd(OFS_DURATION, DURATION_RESET);
		rd(OFS_CMD, 32'h0);
		rd(8'h40, 32'h0);
		for (int n = 0; n < LIMIT_COUNT; n++) begin
			rd(OFS_LIMIT + 8'(4 * n), LIMIT_MIN[n / 2]);
		end
		wr(OFS_DURATION, DURATION_MAX + 32'h1);
		rd(OFS_DURATION, DURATION_MAX);
		v = $urandom % DURATION_MAX;
		wr(OFS_DURATION, v);
		rd(OFS_DURATION, v);
		for (int q = 0; q < 5; q++) begin
			c = ctl(3'(q), q[0], 2'(q % 3), 1'($urandom), 1'($urandom),
				5'(q * 4), 1'b0);
			wr(OFS_CTRL, c);
			rd(OFS_CTRL, c);
		end
		// out-of-range codes: quantity kept, dwell index saturated
		wr(OFS_CTRL, ctl(3'h5, 1'b0, 2'h0, 1'b0, 1'b0, 5'h11, 1'b0));
		c = ctl(3'h4, 1'b0, 2'h0, 1'b0, 1'b0, DWELL_IDX_MAX, 1'b0);
		rd(OFS_CTRL, c);
		for (int n = 0; n < LIMIT_COUNT; n++) begin
			wr(OFS_LIMIT + 8'(4 * n), limW[n]);
			rd(OFS_LIMIT + 8'(4 * n), limE[n]);
		end
		// zero duration gives a single step, so every value is exact
		wr(OFS_LIMIT + 8'h18, 32'h3e8);
		wr(OFS_LIMIT + 8'h1c, 32'h7d0);
		wr(OFS_DURATION, 32'h0);
		lo = 32'h3e8;
		hi = 32'h7d0;
		for (int em = 0; em < 3; em++) begin
			wr(OFS_CTRL, ctl(3'h3, em == 1, 2'(em), 0, 0, 5'h0, 1'b0));
			repeat (2) @(posedge ref_clk);
			r = updCount;
			updQ = {32'h3e8, 32'h3e8, 32'h7d0};
			if (em > 0) updQ = {updQ, 32'h3e8, 32'h7d0};
			wr(OFS_CTRL, ctl(3'h3, em == 1, 2'(em), 0, 0, 5'h0, 1'b1));
			st(ST_RESET);
			repeat (200) @(posedge ref_clk);
			check("idle", 32'(updCount), 32'(r + 1));
			cmd(CMD_RUN);
			st(ST_RUN);
			waitU(r + ((em > 0) ? 5 : 3));
			repeat (300) @(posedge ref_clk);
			st((em > 0) ? ST_RUN : ST_DONE);
		end
		wr(OFS_DURATION, 32'h1);
		wr(OFS_CTRL, ctl(3'h3, 1'b0, 2'h0, 0, 0, 5'h4, 1'b0));
		repeat (2) @(posedge ref_clk);
		r = updCount;
		// six linear steps of 1000..2000, truncated toward begin
		updQ = {32'h3e8, 32'h3e8, 32'h48e, 32'h535, 32'h5dc, 32'h682,
			32'h729, 32'h7d0, 32'h3e8, 32'h48e, 32'h3e8};
		wr(OFS_CTRL, ctl(3'h3, 1'b0, 2'h0, 0, 0, 5'h4, 1'b1));
		cmd(CMD_RUN);
		waitU(r + 2);
		repeat (100) @(posedge ref_clk);
		cmd(CMD_PAUSE);
		st(ST_PAUSE);
		v = out.value;
		cmd(CMD_PAUSE);
		repeat (3000) @(posedge ref_clk);
		st(ST_PAUSE);
		check("held", out.value, v);
		check("no step", 32'(updCount), 32'(r + 2));
		cmd(CMD_RUN);
		st(ST_RUN);
		cmd(CMD_RUN);
		st(ST_RUN);
		waitU(r + 3);
		gapOn = 1'b1;
		waitU(r + 8);
		gapOn = 1'b0;
		// last step still dwells its full interval before done
		repeat (1700) @(posedge ref_clk);
		st(ST_DONE);
		check("end", out.value, 32'h7d0);
		check("steps", 32'(updCount), 32'(r + 8));
		cmd(CMD_RUN);
		st(ST_RUN);
		waitU(r + 10);
		cmd(CMD_RESET);
		st(ST_RESET);
		repeat (2000) @(posedge ref_clk);
		st(ST_RESET);
		check("begin", out.value, 32'h3e8);
		lo = '0;
		hi = '1;
		updQ = {limE[2]};
		wr(OFS_CTRL, ctl(3'h1, 1'b0, 2'h0, 1'b1, 1'b0, 5'h0, 1'b0));
		wr(OFS_CTRL, ctl(3'h1, 1'b0, 2'h0, 1'b1, 1'b0, 5'h0, 1'b1));
		st(ST_RESET);
		check("ampFreeze", 32'(out.ampFreeze), 32'h1);
		check("dcFreeze", 32'(out.dcFreeze), 32'h0);
		check("qty", 32'(out.qty), 32'h1);
		updQ = {limE[4]};
		wr(OFS_CTRL, ctl(3'h2, 1'b0, 2'h0, 1'b1, 1'b1, 5'h0, 1'b0));
		wr(OFS_CTRL, ctl(3'h2, 1'b0, 2'h0, 1'b0, 1'b1, 5'h0, 1'b1));
		st(ST_RESET);
		check("dcFreeze", 32'(out.dcFreeze), 32'h1);
		check("ampFreeze", 32'(out.ampFreeze), 32'h0);
		check("qty", 32'(out.qty), 32'h2);
		wr(OFS_CTRL, ctl(3'h2, 1'b0, 2'h0, 1'b0, 1'b1, 5'h0, 1'b0));
		st(ST_OFF);
		check("dcFreeze", 32'(out.dcFreeze), 32'h0);
		repeat (4) @(posedge ref_clk);
		printVerdict();
	end
	// watchdog: whole run is well under this span
	initial begin
		repeat (60000) @(posedge ref_clk);
		errCount++;
		printVerdict();
	end
endmodule // pss_scan_sequencer_tb
`default_nettype wire
